// ---- tbw_timer_ccr_burst.sv ----
// channel 2..4 value registers, burst control and the burst window
// assumes apb master on pclk; registers outside this block sit on the
// target port, which answers with tgt_ready in the same or later cycle
`timescale 1ns/1ps

// ********************************************************************
// write-command fifo
// ********************************************************************
module tbw_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             push;
    logic             pop;
    // depth must be a power of two for pointer wrap
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two of at least two");
    end
    assign in_ready  = (count != DEPTH[PW:0]);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    // storage
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : tbw_fifo
// ********************************************************************
// top: value registers, burst control and window redirection
// ********************************************************************
module tbw_timer_ccr_burst
    import tbw_pkg::*;
#(
    parameter int FIFO_DEPTH = TBW_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // timer core
    input  wire logic [15:0] counter,
    input  wire logic [2:0]  capture_evt,
    input  wire logic [2:0]  input_mode,
    input  wire logic [2:0]  compare_preload_enable,
    input  wire logic        update_evt,
    output logic      [2:0]  compare_match,
    // registers of the timer outside this block
    output logic             tgt_valid,
    output logic             tgt_write,
    output logic      [7:0]  tgt_addr,
    output logic      [15:0] tgt_wdata,
    input  wire logic [15:0] tgt_rdata,
    input  wire logic        tgt_ready
);
    localparam int EW = TBW_NUM_W + 16;
    localparam logic [7:0] CH_ADDR [TBW_CH_COUNT] = '{TBW_CH2_ADDR, TBW_CH3_ADDR, TBW_CH4_ADDR};
    // ****************************************************************
    // helper functions
    // ****************************************************************
    // register number of a byte address
    function automatic logic [TBW_NUM_W-1:0] num_of(input logic [7:0] a);
        num_of = a[7:2];
    endfunction : num_of
    // register numbers that live inside this block
    function automatic logic is_internal(input logic [TBW_NUM_W-1:0] n);
        is_internal = (n == num_of(TBW_CH2_ADDR)) || (n == num_of(TBW_CH3_ADDR)) ||
                      (n == num_of(TBW_CH4_ADDR)) || (n == num_of(TBW_DCTRL_ADDR)) ||
                      (n == num_of(TBW_WINDOW_ADDR)) || (n == num_of(TBW_MODE_ADDR));
    endfunction : is_internal
    // ****************************************************************
    // state
    // ****************************************************************
    logic [15:0]               value [TBW_CH_COUNT];
    logic [15:0]               active [TBW_CH_COUNT];
    logic [TBW_FIELD_W-1:0]    base;
    logic [TBW_FIELD_W-1:0]    len;
    logic                      byte_mode;
    logic [TBW_NUM_W-1:0]      index;
    logic                      half;
    logic [7:0]                byte_hi;
    logic                      acc;
    logic                      win_hit;
    logic                      win_wr;
    logic                      win_rd;
    logic                      mapped;
    logic                      dir_wr;
    logic                      dctrl_dir_wr;
    logic [TBW_NUM_W-1:0]      num0;
    logic [TBW_NUM_W-1:0]      num1;
    logic [TBW_NUM_W-1:0]      rd_num;
    logic [TBW_NUM_W-1:0]      next_index;
    logic [TBW_NUM_W-1:0]      step;
    logic                      in_valid;
    logic                      in_ready;
    logic [EW-1:0]             in_data;
    logic                      out_valid;
    logic                      out_ready;
    logic [EW-1:0]             out_data;
    logic [TBW_NUM_W-1:0]      d_num;
    logic [15:0]               d_data;
    logic                      d_int;
    logic                      drain_int;
    logic                      rd_go;
    logic                      rd_int;
    logic                      rd_beat;
    logic [15:0]               rd_val;
    logic                      win_wr_done;
    logic                      win_rd_done;
    logic [15:0]               win_rd_data;
    // register read view, shared by direct and window reads
    function automatic logic [15:0] rd_reg(input logic [TBW_NUM_W-1:0] n);
        rd_reg = 16'h0000;
        for (int i = 0; i < TBW_CH_COUNT; i++) begin
            if (n == num_of(CH_ADDR[i])) begin
                rd_reg = value[i];
            end
        end
        if (n == num_of(TBW_DCTRL_ADDR)) begin
            rd_reg = 16'h0000;
            rd_reg[TBW_LEN_LSB +: TBW_FIELD_W]  = len;
            rd_reg[TBW_BASE_LSB +: TBW_FIELD_W] = base;
        end
        if (n == num_of(TBW_MODE_ADDR)) begin
            rd_reg[TBW_MODE_BYTE] = byte_mode;
            rd_reg[TBW_MODE_IDX_LSB +: TBW_NUM_W] = index;
        end
    endfunction : rd_reg
    // ****************************************************************
    // apb decode
    // ****************************************************************
    assign acc     = psel & penable;
    assign win_hit = (paddr == TBW_WINDOW_ADDR);
    assign win_wr  = acc & pwrite & win_hit;
    assign win_rd  = acc & ~pwrite & win_hit;
    assign mapped  = (paddr[1:0] == 2'b00) && is_internal(num_of(paddr));
    assign dir_wr  = acc & pwrite & ~win_hit & mapped;
    assign dctrl_dir_wr = dir_wr && (paddr == TBW_DCTRL_ADDR);
    // ****************************************************************
    // burst addressing
    // ****************************************************************
    // target number is base plus running index
    assign num0   = TBW_NUM_W'(base) + index;
    assign num1   = num0 + 1'b1;
    assign step   = byte_mode ? TBW_NUM_W'(2) : TBW_NUM_W'(1);
    assign next_index = ((index + step) > TBW_NUM_W'(len)) ? '0 : index + step;

    // ****************************************************************
    // window write: queue one or two target writes
    // ****************************************************************
    assign in_valid = win_wr;
    always_comb begin
        if (half) begin
            in_data = {num1, 8'h00, pwdata[7:0]};
        end else if (byte_mode) begin
            in_data = {num0, 8'h00, pwdata[15:8]};
        end else begin
            in_data = {num0, pwdata[15:0]};
        end
    end
    assign win_wr_done = in_valid & in_ready & (~byte_mode | half);

    tbw_fifo #(
        .WIDTH (EW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (in_data),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

    // ****************************************************************
    // drain: apply queued writes inside or on the target port
    // ****************************************************************
    assign d_num     = out_data[EW-1:16];
    assign d_data    = out_data[15:0];
    assign d_int     = is_internal(d_num);
    assign out_ready = d_int | tgt_ready;
    assign drain_int = out_valid & d_int;

    // ****************************************************************
    // window read: waits until queued writes have landed
    // ****************************************************************
    assign rd_num  = half ? num1 : num0;
    assign rd_go   = win_rd & ~out_valid;
    assign rd_int  = is_internal(rd_num);
    assign rd_beat = rd_go & (rd_int | tgt_ready);
    // register views follow every register change, not only the address
    always_comb begin
        rd_val = rd_int ? rd_reg(rd_num) : tgt_rdata;
        prdata = {16'h0000, win_hit ? win_rd_data : (mapped ? rd_reg(num_of(paddr)) : 16'h0000)};
    end
    assign win_rd_done = rd_beat & (~byte_mode | half);
    assign win_rd_data = byte_mode ? {byte_hi, rd_val[7:0]} : rd_val;

    // target port, drain has priority over reads
    assign tgt_valid = out_valid ? ~d_int : (rd_go & ~rd_int);
    assign tgt_write = out_valid;
    assign tgt_addr  = TBW_CTRL1_ADDR + {out_valid ? d_num : rd_num, 2'b00};
    assign tgt_wdata = d_data;

    // ****************************************************************
    // apb answer
    // ****************************************************************
    assign pready  = win_hit ? (pwrite ? win_wr_done : win_rd_done) : 1'b1;
    assign pslverr = acc & pready & ~mapped;

    // ****************************************************************
    // burst sequencing
    // ****************************************************************
    // byte half of a split transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half <= 1'b0;
        end else if (dctrl_dir_wr) begin
            half <= 1'b0;
        end else if (byte_mode && ((in_valid && in_ready) || rd_beat)) begin
            half <= ~half;
        end
    end

    // running index, restarts once the next step would pass the burst length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index <= '0;
        end else if (dctrl_dir_wr) begin
            index <= '0;
        end else if (win_wr_done || win_rd_done) begin
            index <= next_index;
        end
    end

    // most significant byte held from the first read half
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_hi <= 8'h00;
        end else if (rd_beat && byte_mode && !half) begin
            byte_hi <= rd_val[7:0];
        end
    end

    // ****************************************************************
    // burst control and mode registers
    // ****************************************************************
    // direct write is applied last so it wins over a queued one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base <= TBW_DCTRL_RESET[TBW_BASE_LSB +: TBW_FIELD_W];
            len  <= TBW_DCTRL_RESET[TBW_LEN_LSB +: TBW_FIELD_W];
        end else begin
            if (drain_int && d_num == num_of(TBW_DCTRL_ADDR)) begin
                base <= d_data[TBW_BASE_LSB +: TBW_FIELD_W];
                len  <= d_data[TBW_LEN_LSB +: TBW_FIELD_W];
            end
            if (dctrl_dir_wr) begin
                base <= pwdata[TBW_BASE_LSB +: TBW_FIELD_W];
                len  <= pwdata[TBW_LEN_LSB +: TBW_FIELD_W];
            end
        end
    end

    // data size select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_mode <= TBW_MODE_RESET[TBW_MODE_BYTE];
        end else begin
            if (drain_int && d_num == num_of(TBW_MODE_ADDR)) begin
                byte_mode <= d_data[TBW_MODE_BYTE];
            end
            if (dir_wr && paddr == TBW_MODE_ADDR) begin
                byte_mode <= pwdata[TBW_MODE_BYTE];
            end
        end
    end

    // ****************************************************************
    // channel value registers
    // ****************************************************************
    for (genvar i = 0; i < TBW_CH_COUNT; i++) begin : g_ch
        logic        sel_a;
        logic        sel_d;
        logic [15:0] wdat;

        assign sel_a = dir_wr && (paddr == CH_ADDR[i]);
        assign sel_d = drain_int && (d_num == num_of(CH_ADDR[i]));
        assign wdat  = sel_a ? pwdata[15:0] : d_data;

        // capture wins, then software write, then update load
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                value[i]  <= TBW_CC_RESET;
                active[i] <= TBW_CC_RESET;
            end else if (capture_evt[i] && input_mode[i]) begin
                value[i]  <= counter;
                active[i] <= counter;
            end else if (sel_a || sel_d) begin
                value[i] <= wdat;
                if (!compare_preload_enable[i]) begin
                    active[i] <= wdat;
                end
            end else if (update_evt && compare_preload_enable[i]) begin
                active[i] <= value[i];
            end
        end

        // compare against counter in output mode
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                compare_match[i] <= 1'b0;
            end else begin
                compare_match[i] <= !input_mode[i] && (counter == active[i]);
            end
        end
    end
endmodule : tbw_timer_ccr_burst

// ---- tbw_pkg.sv ----
// constants for the capture/compare value registers and the burst window
// assumes a 32-bit apb slave decoding an 8-bit byte address space
package tbw_pkg;

    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [7:0] TBW_CTRL1_ADDR   = 8'h00;
    localparam logic [7:0] TBW_CH2_ADDR     = 8'h38;
    localparam logic [7:0] TBW_CH3_ADDR     = 8'h3c;
    localparam logic [7:0] TBW_CH4_ADDR     = 8'h40;
    localparam logic [7:0] TBW_DCTRL_ADDR   = 8'h48;
    localparam logic [7:0] TBW_WINDOW_ADDR  = 8'h4c;
    localparam logic [7:0] TBW_MODE_ADDR    = 8'h50;

    // ****************************************************************
    // field layout and reset values
    // ****************************************************************
    localparam int          TBW_BASE_LSB    = 0;
    localparam int          TBW_LEN_LSB     = 8;
    localparam int          TBW_FIELD_W     = 5;
    localparam int          TBW_MODE_BYTE   = 0;
    localparam int          TBW_MODE_IDX_LSB = 8;
    localparam logic [15:0] TBW_CC_RESET    = 16'h0000;
    localparam logic [15:0] TBW_DCTRL_RESET = 16'h0000;
    localparam logic [15:0] TBW_MODE_RESET  = 16'h0000;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int TBW_CH_COUNT   = 3;
    localparam int TBW_NUM_W      = 6;
    localparam int TBW_FIFO_DEPTH = 4;

endpackage : tbw_pkg

// ---- tbw_burst_props.sv ----
// checker for the apb side and target port of the burst window block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
// ********************************************************************
// checker module
// ********************************************************************
module tbw_burst_props
    import tbw_pkg::*;
#(
    parameter int FIFO_DEPTH = TBW_FIFO_DEPTH
) (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // timer core
    input wire logic [2:0]  input_mode,
    input wire logic [2:0]  compare_match,
    // target port
    input wire logic        tgt_valid,
    input wire logic        tgt_write,
    input wire logic [7:0]  tgt_addr,
    input wire logic [15:0] tgt_wdata,
    input wire logic        tgt_ready
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase to one address, and a target request left waiting
    sequence s_acc(logic [7:0] a);
        psel && penable && paddr == a;
    endsequence
    sequence s_tgt_wait;
        tgt_valid && !tgt_ready;
    endsequence
    direct_zero_wait_a: assert property (psel && penable && paddr != TBW_WINDOW_ADDR |-> pready)
        else $error("direct access not answered at once");
    bad_addr_err_a: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pready && pslverr)
        else $error("misaligned access not refused");
    good_addr_ok_a: assert property (psel && penable && paddr inside {8'h38, 8'h3c, 8'h40, 8'h48, 8'h4c} |-> !pslverr)
        else $error("mapped access refused");
    upper_half_zero_a: assert property (psel && penable && !pwrite && pready |-> prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    rsvd_read_zero_a: assert property (s_acc(TBW_DCTRL_ADDR) ##0 !pwrite |-> prdata[7:5] == 3'b000 && prdata[15:13] == 3'b000)
        else $error("burst control reserved bits not zero");
    tgt_word_step_a: assert property (tgt_valid |-> tgt_addr[1:0] == 2'b00)
        else $error("target address not a word address");
    tgt_req_hold_a: assert property (s_tgt_wait |=> tgt_valid && $stable(tgt_addr) && $stable(tgt_write) && $stable(tgt_wdata))
        else $error("target request changed while waiting");
    tgt_read_window_a: assert property (tgt_valid && !tgt_write |-> s_acc(TBW_WINDOW_ADDR) ##0 !pwrite)
        else $error("target read outside a window read");
    match_out_mode_a: assert property (|compare_match |-> (compare_match & $past(input_mode)) == 3'b000)
        else $error("compare match on an input channel");
endmodule : tbw_burst_props

bind tbw_timer_ccr_burst tbw_burst_props #(.FIFO_DEPTH(FIFO_DEPTH)) i_tbw_burst_props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .input_mode, .compare_match, .tgt_valid, .tgt_write, .tgt_addr, .tgt_wdata, .tgt_ready);

// ---- tbw_target_model.sv ----
// model of the timer registers that live outside the block
// assumes one request at a time on the target port, paced by slow
`timescale 1ns/1ps
module tbw_target_model (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // answer delay in cycles, changed only while idle
    input wire logic [3:0]  slow,
    // target port
    input wire logic        tgt_valid,
    input wire logic        tgt_write,
    input wire logic [7:0]  tgt_addr,
    input wire logic [15:0] tgt_wdata,
    output logic     [15:0] tgt_rdata,
    output logic            tgt_ready
);
    logic [15:0] mem [0:31];
    logic [3:0]  wait_cnt;
    // word index from the byte address; data off the answer cycle is scrambled
    assign tgt_ready = tgt_valid && (wait_cnt >= slow);
    assign tgt_rdata = tgt_ready ? mem[tgt_addr[6:2]] : ~mem[tgt_addr[6:2]] ^ {12'h000, wait_cnt};
    // wait counter and register storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 4'h0;
            for (int i = 0; i < 32; i++) mem[i] <= 16'h0000;
        end else if (tgt_ready) begin
            wait_cnt <= 4'h0;
            if (tgt_write) mem[tgt_addr[6:2]] <= tgt_wdata;
        end else if (tgt_valid) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : tbw_target_model

// ---- testbench.sv ----
// self-checking bench for the burst window block
// assumes the outside registers are modelled by tbw_target_model
`timescale 1ns/1ps
module testbench
    import tbw_pkg::*;
;
    typedef struct packed {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] e; logic err;} tbw_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, update_evt;
    logic        tgt_valid, tgt_write, tgt_ready, erv;
    logic [7:0]  paddr, tgt_addr;
    logic [31:0] pwdata, prdata, rdv;
    logic [15:0] counter, tgt_wdata, tgt_rdata;
    logic [2:0]  capture_evt, input_mode, compare_preload_enable, compare_match;
    logic [3:0]  slow;
    int          n_errors, checks, last_wait, mx;
    tbw_row_t    rows [13] = '{
        '{1'b0, 8'h38, 16'h0000, 16'h0000, 1'b0}, '{1'b0, 8'h3c, 16'h0000, 16'h0000, 1'b0},
        '{1'b0, 8'h40, 16'h0000, 16'h0000, 1'b0}, '{1'b0, 8'h48, 16'h0000, 16'h0000, 1'b0},
        '{1'b1, 8'h38, 16'h1234, 16'h1234, 1'b0}, '{1'b1, 8'h3c, 16'habcd, 16'habcd, 1'b0},
        '{1'b1, 8'h40, 16'hffff, 16'hffff, 1'b0}, '{1'b1, 8'h48, 16'hffff, 16'h1f1f, 1'b0},
        '{1'b1, 8'h48, 16'h0302, 16'h0302, 1'b0}, '{1'b1, 8'h50, 16'h0001, 16'h0001, 1'b0},
        '{1'b1, 8'h50, 16'h0000, 16'h0000, 1'b0}, '{1'b1, 8'h44, 16'h5555, 16'h0000, 1'b1},
        '{1'b1, 8'h3a, 16'h5555, 16'h0000, 1'b1}};

    tbw_timer_ccr_burst i_tbw_timer_ccr_burst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .counter, .capture_evt, .input_mode, .compare_preload_enable,
        .update_evt, .compare_match, .tgt_valid, .tgt_write, .tgt_addr, .tgt_wdata, .tgt_rdata, .tgt_ready);
    tbw_target_model i_tbw_target_model (.pclk, .presetn, .slow, .tgt_valid, .tgt_write, .tgt_addr,
        .tgt_wdata, .tgt_rdata, .tgt_ready);

    // ****************************************************************
    // clock, tasks and watchdog
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; read data and error taken where pready is high
    task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 300; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 300) begin
            n_errors++;
            $display("FAIL %0t: no pready", $time);
        end
        last_wait = n;
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task test_done;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    initial begin
        #100000;
        n_errors++;
        test_done;
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, counter, capture_evt, update_evt} = '0;
        input_mode = 3'b001;
        compare_preload_enable = 3'b010;
        slow = 4'hc;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 16'h0000);
            chk(rdv, {16'h0000, rows[i].e});
            chk({31'h0, erv}, {31'h0, rows[i].err});
        end
        // nine window writes to a slow target: fifo stalls, index wraps
        apb(1'b1, TBW_DCTRL_ADDR, 16'h0702);
        mx = 0;
        for (int k = 0; k < 9; k++) begin
            apb(1'b1, TBW_WINDOW_ADDR, 16'h1100 + 16'(k));
            if (last_wait > mx) mx = last_wait;
        end
        chk({31'h0, mx > 1}, 32'h1);
        apb(1'b0, TBW_WINDOW_ADDR, 16'h0000);
        chk(rdv, 32'h1101);
        apb(1'b0, TBW_MODE_ADDR, 16'h0000);
        chk(rdv, 32'h0200);
        for (int k = 1; k < 8; k++) chk({16'h0, i_tbw_target_model.mem[2 + k]}, 32'h1100 + k);
        chk({16'h0, i_tbw_target_model.mem[2]}, 32'h1108);
        // burst crossing from an outside register into channel 2
        slow <= 4'h0;
        apb(1'b1, TBW_DCTRL_ADDR, 16'h010d);
        apb(1'b1, TBW_WINDOW_ADDR, 16'h0aaa);
        apb(1'b1, TBW_WINDOW_ADDR, 16'h0bbb);
        apb(1'b0, TBW_CH2_ADDR, 16'h0000);
        chk(rdv, 32'h0bbb);
        chk({16'h0, i_tbw_target_model.mem[13]}, 32'h0aaa);
        // byte mode: high byte to the first register, low byte to the next
        apb(1'b1, TBW_MODE_ADDR, 16'h0001);
        apb(1'b1, TBW_DCTRL_ADDR, 16'h010e);
        apb(1'b1, TBW_WINDOW_ADDR, 16'ha5c3);
        apb(1'b0, TBW_CH2_ADDR, 16'h0000);
        chk(rdv, 32'h00a5);
        apb(1'b0, TBW_CH3_ADDR, 16'h0000);
        chk(rdv, 32'h00c3);
        apb(1'b1, TBW_DCTRL_ADDR, 16'h010e);
        apb(1'b0, TBW_WINDOW_ADDR, 16'h0000);
        chk(rdv, 32'ha5c3);
        apb(1'b1, TBW_MODE_ADDR, 16'h0000);
        // capture on channel 2
        counter <= 16'h4321;
        capture_evt <= 3'b001;
        @(posedge pclk);
        capture_evt <= 3'b000;
        apb(1'b0, TBW_CH2_ADDR, 16'h0000);
        chk(rdv, 32'h4321);
        // channel 3 preloaded, channel 4 immediate
        counter <= 16'h0010;
        apb(1'b1, TBW_CH3_ADDR, 16'h0010);
        apb(1'b1, TBW_CH4_ADDR, 16'h0010);
        repeat (3) @(posedge pclk);
        chk({29'h0, compare_match}, 32'h4);
        update_evt <= 1'b1;
        @(posedge pclk);
        update_evt <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({29'h0, compare_match}, 32'h6);
        // second reset in mid-run clears the values
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, TBW_CH3_ADDR, 16'h0000);
        chk(rdv, 32'h0000);
        chk({29'h0, compare_match}, 32'h0);
        test_done;
    end
endmodule : testbench
